// *** shared/tlsm_map.svh ***
// Register offsets, reset values and timing constants of the load manager.
`ifndef TLSM_MAP_SVH
`define TLSM_MAP_SVH

// Clock period and step tick, both in nanoseconds.
`define TLSM_CLK_PERIOD_NS 100
`define TLSM_TICK_NS       100000000

// Step interval limits and default, counted in 0.1 s ticks.
`define TLSM_IVL_DEFAULT   13'h000a
`define TLSM_IVL_MIN       13'h0001
`define TLSM_IVL_MAX       13'h1770
`define TLSM_IVL_ONE       13'h0001

// Default maximum count: one more than the two managed outputs.
`define TLSM_MAX_DEFAULT   5'h03
`define TLSM_COUNT_ONE     5'h01

// Register byte offsets.
`define TLSM_OFS_MAX       8'h00
`define TLSM_OFS_SHED_IVL  8'h04
`define TLSM_OFS_LOAD_IVL  8'h08
`define TLSM_OFS_STATUS    8'h0c
`define TLSM_OFS_DIAG      8'h10
`define TLSM_OFS_SEQ_BASE  8'h20
`define TLSM_OFS_SEQ_STEP  8'h04

// Status register field positions.
`define TLSM_ST_KEY        8
`define TLSM_ST_SHED       9
`define TLSM_ST_LOAD       10

`endif

// *** shared/tlsm_pkg.sv ***
// Types shared by the load manager modules.
package tlsm_pkg;
  // Step counter value.
  typedef logic [4:0]  tlsm_count_t;
  // Interval length in 0.1 s ticks.
  typedef logic [12:0] tlsm_ivl_t;
  // Register bus address and data.
  typedef logic [7:0]  tlsm_addr_t;
  typedef logic [15:0] tlsm_data_t;
endpackage

// *** shared/tlsm_step_if.sv ***
// Carrier between the manager core and one of its interval timers.
interface tlsm_step_if;
  logic                tick;      // One-cycle pulse every 0.1 s.
  logic                cond;      // Shed or load condition level.
  tlsm_pkg::tlsm_ivl_t interval;  // Programmed interval in ticks.
  logic                step;      // One-cycle request to step the count.

  modport timer (input tick, input cond, input interval, output step);
  modport mgr   (output tick, output cond, output interval, input step);
endinterface

// *** hdl/tlsm_interval_timer.sv ***
// Interval timer that asks the manager for one count step per interval.
`include "tlsm_map.svh"
module tlsm_interval_timer #(
  parameter bit FIRST_IMMEDIATE = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  tlsm_step_if.timer stp
);
  import tlsm_pkg::*;

  logic      cond_q_reg;   // Condition seen on the previous cycle.
  tlsm_ivl_t cnt_reg;      // Ticks elapsed in the current interval.
  tlsm_ivl_t cnt_next;
  logic      step_reg;     // Registered step request.
  logic      step_next;

  // Next tick count and whether it completes the interval.
  wire tlsm_ivl_t cnt_plus = cnt_reg + `TLSM_IVL_ONE;
  // [RULE2] immediate first step
  wire first_step = FIRST_IMMEDIATE && stp.cond && !cond_q_reg;
  // [RULE1] step on expiry
  wire expire = stp.cond && stp.tick && (cnt_plus >= stp.interval);

  assign step_next = first_step || expire;
  // [RULE19] restart on deassert or step
  assign cnt_next = (!stp.cond || step_next) ? '0
                  : (stp.tick ? cnt_plus : cnt_reg);
  assign stp.step = step_reg;

  // Interval state; a late tick inside the first interval is the only
  // jitter, since the tick prescaler is shared and free running.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cond_q_reg <= 1'b0;
      cnt_reg    <= '0;
      step_reg   <= 1'b0;
    end else begin
      cond_q_reg <= stp.cond;
      cnt_reg    <= cnt_next;
      step_reg   <= step_next;
    end
  end
endmodule

// *** hdl/tlsm_top.sv ***
// Timed load shed manager: step counter, output enables and indicators.
//
// Functional notes
// [RULE1] Shed step lowers count by one.
// [RULE2] First shed step happens at once.
// [RULE3] Shed needs switch on and low voltage.
// [RULE4] Count stops at zero; zero means off.
// [RULE5] Load step raises count, holds at maximum.
// [RULE6] First load step after full interval.
// [RULE7] Shed and load intervals set separately.
// [RULE8] Intervals default to one second.
// [RULE9] Intervals range 0.1 s to 600 s.
// [RULE10] Key-on or switch-off reloads maximum.
// [RULE11] Maximum is outputs plus one.
// [RULE12] High trip half volt above low.
// [RULE13] Act only with key in accessory/run; a switch-off reload still acts with the key off.
// [RULE14] Green indicator lit only while output on.
// [RULE15] Check faults only while on; fast flash.
// [RULE16] Open circuit flashes, raises no fault code.
// [RULE17] Independent instances may run side by side.
// [RULE18] Output on while count reaches its number.
// [RULE19] Timers restart on deassert or step.
// [RULE20] Both conditions true: count unchanged.
`include "tlsm_map.svh"
module tlsm_top #(
  parameter int NUM_OUT     = 2,
  parameter int TICK_CYCLES = `TLSM_TICK_NS / `TLSM_CLK_PERIOD_NS
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire tlsm_pkg::tlsm_addr_t reg_addr,
  input  wire tlsm_pkg::tlsm_data_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output      tlsm_pkg::tlsm_data_t reg_rdata,
  input  wire logic               key_acc_run,
  input  wire logic               shed_switch_on,
  input  wire logic               volt_below_low,
  input  wire logic               volt_above_high,
  input  wire logic [NUM_OUT-1:0] output_open_circuit,
  input  wire logic [NUM_OUT-1:0] output_overload,
  output      logic [NUM_OUT-1:0] managed_output_en,
  output      logic [NUM_OUT-1:0] rocker_indicator,
  output      logic               system_fault_code
);
  import tlsm_pkg::*;

  // Each instance holds all of its own state, so several managers with
  // their own counters, conditions and intervals run side by side.
  // [RULE17] instance-local state only

  // Tick prescaler and fast flash phase.
  logic [31:0]  pre_reg;       // Cycles since the last 0.1 s tick.
  logic         tick_reg;      // One-cycle 0.1 s tick.
  logic         flash_reg;     // Fast flash phase, toggles every tick.

  // Edge detection of key and switch.
  logic         key_q_reg;     // Key level on the previous cycle.
  logic         sw_q_reg;      // Shed switch level on the previous cycle.

  // Software visible settings.
  tlsm_count_t  max_reg;       // Maximum count.
  tlsm_ivl_t    shed_ivl_reg;  // Shed interval in ticks.
  tlsm_ivl_t    load_ivl_reg;  // Load interval in ticks.
  tlsm_count_t  seq_reg [NUM_OUT];  // Sequence number of each output.

  // Manager state.
  tlsm_count_t  count_reg;     // The step counter.
  tlsm_count_t  count_next;
  logic [NUM_OUT-1:0] overload_reg;  // Sticky overload flags.
  logic [NUM_OUT-1:0] out_en_next;
  logic [NUM_OUT-1:0] ind_next;
  logic [NUM_OUT-1:0] ovl_next;
  tlsm_data_t   rdata_reg;     // Registered read data.

  // Timer carriers.
  tlsm_step_if shed_if ();
  tlsm_step_if load_if ();

  // Clamp a written interval into the legal range.
  function automatic tlsm_ivl_t clamp_ivl(input tlsm_data_t v);
    tlsm_ivl_t r;
    r = v[12:0];
    if (v[15:13] != 3'h0 || r > `TLSM_IVL_MAX) begin
      r = `TLSM_IVL_MAX;
    end else if (r < `TLSM_IVL_MIN) begin
      r = `TLSM_IVL_MIN;
    end
    return r;
  endfunction

  // Prescaler end of period.
  wire pre_wrap = (pre_reg == 32'(TICK_CYCLES - 1));

  // Free running 0.1 s tick; the flash phase rides on it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pre_reg   <= '0;
      tick_reg  <= 1'b0;
      flash_reg <= 1'b0;
    end else begin
      pre_reg   <= pre_wrap ? '0 : pre_reg + 32'h0000_0001;
      tick_reg  <= pre_wrap;
      flash_reg <= flash_reg ^ tick_reg;
    end
  end

  // Conditions. With the key off both are held low, so no step acts; a switch-off reload still loads the maximum.
  // [RULE13] key gating
  wire key_on = key_acc_run;
  // [RULE3] shed condition
  wire shed_cond = key_on && shed_switch_on && volt_below_low;
  // The trip dead band is set by whoever drives the two voltage flags.
  // [RULE12] dead band outside
  wire load_cond = key_on && volt_above_high;

  // [RULE10] reload events
  wire key_rise = key_on && !key_q_reg;
  wire sw_fall  = !shed_switch_on && sw_q_reg;
  wire reload   = key_rise || sw_fall;

  // Timers: shed steps at once on entry, load waits a full interval.
  assign shed_if.tick     = tick_reg;
  assign shed_if.cond     = shed_cond;
  // [RULE7] separate intervals
  assign shed_if.interval = shed_ivl_reg;
  assign load_if.tick     = tick_reg;
  assign load_if.cond     = load_cond;
  assign load_if.interval = load_ivl_reg;

  tlsm_interval_timer #(.FIRST_IMMEDIATE(1'b1)) u_shed_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .stp     (shed_if.timer)
  );

  // [RULE6] no immediate load step
  tlsm_interval_timer #(.FIRST_IMMEDIATE(1'b0)) u_load_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .stp     (load_if.timer)
  );

  // Step decisions.
  // While both conditions hold the count is frozen, so a shed entry step
  // cannot slip through while the load side also asks for a change.
  // [RULE20] conflicting conditions freeze count
  wire both_step = (shed_if.step && load_if.step) || (shed_cond && load_cond);
  // [RULE4] floor at zero
  wire can_dec = (count_reg != '0);
  // [RULE5] ceiling at maximum
  wire can_inc = (count_reg < max_reg);

  // Counter next value; a reload outranks any step.
  always_comb begin
    count_next = count_reg;
    if (reload) begin
      count_next = max_reg;
    end else if (both_step) begin
      count_next = count_reg;
    end else if (shed_if.step && can_dec) begin
      // [RULE1] decrement by one
      count_next = count_reg - `TLSM_COUNT_ONE;
    end else if (load_if.step && can_inc) begin
      count_next = count_reg + `TLSM_COUNT_ONE;
    end
  end

  // Register bus decode.
  wire wr_max  = reg_wr && (reg_addr == `TLSM_OFS_MAX);
  wire wr_shed = reg_wr && (reg_addr == `TLSM_OFS_SHED_IVL);
  wire wr_load = reg_wr && (reg_addr == `TLSM_OFS_LOAD_IVL);
  wire wr_diag = reg_wr && (reg_addr == `TLSM_OFS_DIAG);

  // Status word: count in the low bits, live levels above.
  tlsm_data_t status_word;
  always_comb begin
    status_word = '0;
    status_word[4:0] = count_reg;
    status_word[`TLSM_ST_KEY]  = key_on;
    status_word[`TLSM_ST_SHED] = shed_cond;
    status_word[`TLSM_ST_LOAD] = load_cond;
  end

  // Per-output logic: sequence register, enable, indicator, diagnostics.
  tlsm_data_t seq_rd [NUM_OUT];
  logic [NUM_OUT-1:0] seq_hit;
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      // Sequence registers count down from one below the maximum.
      // [RULE11] default numbering
      localparam tlsm_count_t SEQ_RST =
        5'(`TLSM_MAX_DEFAULT - 5'(g) - `TLSM_COUNT_ONE);
      localparam tlsm_addr_t SEQ_OFS =
        8'(`TLSM_OFS_SEQ_BASE + 8'(g) * `TLSM_OFS_SEQ_STEP);
      wire wr_seq = reg_wr && (reg_addr == SEQ_OFS);
      assign seq_hit[g] = (reg_addr == SEQ_OFS);
      assign seq_rd[g]  = {11'h000, seq_reg[g]};

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          seq_reg[g] <= SEQ_RST;
        end else if (wr_seq) begin
          seq_reg[g] <= reg_wdata[4:0];
        end
      end

      // [RULE18] compare count to sequence number
      assign out_en_next[g] = (count_next >= seq_reg[g]);

      // Faults only count while the output is commanded on.
      // [RULE15] gated check, fast flash
      wire fault_seen = managed_output_en[g] &&
                        (output_open_circuit[g] || output_overload[g]);
      // [RULE14] green follows output
      assign ind_next[g] = out_en_next[g] &&
                           (fault_seen ? flash_reg : 1'b1);

      // Overload is sticky and raises the fault code; a new overload in
      // the clearing cycle wins over the clear.
      // [RULE16] open circuit excluded
      assign ovl_next[g] =
        (managed_output_en[g] && output_overload[g]) ||
        (overload_reg[g] && !(wr_diag && reg_wdata[g]));
    end
  endgenerate

  // Read mux, one selected word per address.
  tlsm_data_t rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      `TLSM_OFS_MAX:      rd_mux = {11'h000, max_reg};
      `TLSM_OFS_SHED_IVL: rd_mux = {3'h0, shed_ivl_reg};
      `TLSM_OFS_LOAD_IVL: rd_mux = {3'h0, load_ivl_reg};
      `TLSM_OFS_STATUS:   rd_mux = status_word;
      `TLSM_OFS_DIAG:     rd_mux = 16'(overload_reg);
      default: begin
        for (int i = 0; i < NUM_OUT; i++) begin
          if (seq_hit[i]) begin
            rd_mux = seq_rd[i];
          end
        end
      end
    endcase
  end

  // Settings. Intervals are clamped so no write leaves the legal range.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      max_reg      <= `TLSM_MAX_DEFAULT;
      // [RULE8] one second default
      shed_ivl_reg <= `TLSM_IVL_DEFAULT;
      load_ivl_reg <= `TLSM_IVL_DEFAULT;
    end else begin
      if (wr_max) begin
        max_reg <= reg_wdata[4:0];
      end
      // [RULE9] range clamp
      if (wr_shed) begin
        shed_ivl_reg <= clamp_ivl(reg_wdata);
      end
      if (wr_load) begin
        load_ivl_reg <= clamp_ivl(reg_wdata);
      end
    end
  end

  // Manager state and outputs. Reset loads the maximum count as key-on does, but clears all outputs.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      key_q_reg         <= 1'b0;
      sw_q_reg          <= 1'b0;
      count_reg         <= `TLSM_MAX_DEFAULT;
      managed_output_en <= '0;
      rocker_indicator  <= '0;
      overload_reg      <= '0;
      system_fault_code <= 1'b0;
    end else begin
      key_q_reg         <= key_on;
      sw_q_reg          <= shed_switch_on;
      count_reg         <= count_next;
      managed_output_en <= out_en_next;
      rocker_indicator  <= ind_next;
      overload_reg      <= ovl_next;
      system_fault_code <= |ovl_next;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule

// *** testbench/tlsm_top_sva.sv ***
// Port-level assertions for the load manager, bound into its top module.
module tlsm_chk #(
  parameter int NUM_OUT     = 2,
  parameter int TICK_CYCLES = 10
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               key_acc_run,
  input wire logic               shed_switch_on,
  input wire logic               volt_below_low,
  input wire logic               volt_above_high,
  input wire logic [NUM_OUT-1:0] output_overload,
  input wire logic [NUM_OUT-1:0] managed_output_en,
  input wire logic [NUM_OUT-1:0] rocker_indicator,
  input wire logic               system_fault_code
);
  timeunit 1ns;
  timeprecision 1ns;
  import tlsm_pkg::*;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Conditions as the manager should see them.
  wire logic shed_c = key_acc_run && shed_switch_on && volt_below_low;
  wire logic load_c = key_acc_run && volt_above_high;
  wire logic [NUM_OUT-1:0] ov_on = output_overload & managed_output_en;
  // A reload shows as every output on within two cycles.
  sequence s_all_on;
    ##[1:2] (&managed_output_en);
  endsequence
  // The immediate shed step lands within the pipeline delay.
  sequence s_last_off;
    ##[2:3] (managed_output_en == '0);
  endsequence
  lamp_off_a: assert property (
    (rocker_indicator & ~managed_output_en & ~$past(managed_output_en)) == '0)
    else $error("lamp lit while its output is off");
  fault_cause_a: assert property (
    $rose(system_fault_code) |->
    ($past(ov_on) | $past(ov_on, 2) | $past(ov_on, 3)) != '0)
    else $error("fault code without overload on a driven output");
  reload_switch_a: assert property (
    $fell(shed_switch_on) |-> s_all_on)
    else $error("switch off did not turn all outputs on");
  reload_key_a: assert property (
    $rose(key_acc_run) |-> s_all_on)
    else $error("key on did not turn all outputs on");
  shed_first_a: assert property (
    $rose(shed_c) && managed_output_en == 2'h2 |-> s_last_off)
    else $error("first shed step was not immediate");
  both_hold_a: assert property (
    (shed_c && load_c) [*4] |-> $stable(managed_output_en))
    else $error("outputs moved with both conditions true");
  key_off_a: assert property (
    (!key_acc_run && !$fell(shed_switch_on)) [*5]
    |-> $stable(managed_output_en))
    else $error("outputs moved with key off");
  step_down_a: assert property (
    $fell(managed_output_en[1]) |-> $past(managed_output_en) == 2'h2)
    else $error("count skipped a step on the way down");
endmodule

bind tlsm_top tlsm_chk #(.NUM_OUT(NUM_OUT), .TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .reset_n(reset_n), .key_acc_run(key_acc_run),
  .shed_switch_on(shed_switch_on), .volt_below_low(volt_below_low),
  .volt_above_high(volt_above_high), .output_overload(output_overload),
  .managed_output_en(managed_output_en), .rocker_indicator(rocker_indicator),
  .system_fault_code(system_fault_code));

// *** testbench/tlsm_power_unit.sv ***
// Model of the remote power unit outputs behind the managed outputs.
module tlsm_power_unit #(
  parameter int NUM_OUT = 2
) (
  input  wire logic [NUM_OUT-1:0] managed_output_en,
  input  wire logic [NUM_OUT-1:0] load_open,
  input  wire logic [NUM_OUT-1:0] load_heavy,
  output wire logic [NUM_OUT-1:0] output_open_circuit,
  output wire logic [NUM_OUT-1:0] output_overload
);
  timeunit 1ns;
  timeprecision 1ns;
  // A broken lamp reads open even when undriven, so the manager must gate.
  assign output_open_circuit = load_open;
  // Overcurrent can only flow while the output is driven.
  assign output_overload = load_heavy & managed_output_en;
endmodule

// *** testbench/test_timed_load_shed_manager.sv ***
// Self-checking bench for the timed load shed manager.
module test_timed_load_shed_manager;
  timeunit 1ns;
  timeprecision 1ns;
  import tlsm_pkg::*;
  logic        clk, reset_n, reg_wr, reg_rd, look, rd_seen;
  logic        key_acc_run, shed_switch_on, volt_below_low, volt_above_high;
  logic [1:0]  load_open, load_heavy, oc, ov, en, ind;
  logic        fault;
  tlsm_addr_t  reg_addr;
  tlsm_data_t  reg_wdata, reg_rdata;
  int          errors, compares;
  int unsigned r;
  tlsm_data_t  exp_rd[$];       // Expected read data, oldest first.
  logic [4:0]  exp_out[$];      // Expected {fault, lamps, enables}.
  tlsm_addr_t  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24, 8'h14};
  tlsm_data_t  rv[6] = '{16'h3, 16'ha, 16'ha, 16'h2, 16'h1, 16'h0};

  tlsm_top #(.NUM_OUT(2), .TICK_CYCLES(10)) dut (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .key_acc_run(key_acc_run), .shed_switch_on(shed_switch_on),
    .volt_below_low(volt_below_low), .volt_above_high(volt_above_high),
    .output_open_circuit(oc), .output_overload(ov),
    .managed_output_en(en), .rocker_indicator(ind),
    .system_fault_code(fault));
  tlsm_power_unit #(.NUM_OUT(2)) rpu (.managed_output_en(en),
    .load_open(load_open), .load_heavy(load_heavy),
    .output_open_circuit(oc), .output_overload(ov));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cmp_word(input tlsm_data_t e, input tlsm_data_t g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_out(input logic [4:0] e, input logic [4:0] g);
    cmp_word({11'h000, e}, {11'h000, g});
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Results are judged in the cycle they stand, against the oldest note.
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1) begin
      cmp_word(exp_rd.pop_front(), reg_rdata);
    end
    if (look === 1'b1) begin
      cmp_out(exp_out.pop_front(), {fault, ind, en});
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input tlsm_addr_t a, input tlsm_data_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input tlsm_addr_t a, input tlsm_data_t e);
    exp_rd.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // Status read plus output snapshot; lamps follow enables when healthy.
  task automatic probe(input logic [4:0] c, input logic [2:0] fl);
    logic [1:0] e;
    e = {c >= 5'h01, c >= 5'h02};
    rd(8'h0c, {5'h00, fl, 3'h0, c});
    exp_out.push_back({1'b0, e, e});
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
    @(posedge clk);
  endtask
  // Counts lamp 0 toggles and fault-code cycles over four ticks.
  task automatic watch(input int tog, input int flt);
    logic p;
    int   n;
    int   f;
    p = ind[0];
    n = 0;
    f = 0;
    repeat (40) begin
      @(posedge clk);
      n += (ind[0] !== p);
      f += (fault === 1'b1);
      p = ind[0];
    end
    cmp_word(tog[15:0], n[15:0]);
    cmp_word(flt[15:0], f[15:0]);
  endtask

  initial begin
    {reset_n, reg_wr, reg_rd, look} = 4'h0;
    {key_acc_run, shed_switch_on, volt_below_low, volt_above_high} = 4'h0;
    {load_open, load_heavy, reg_addr, reg_wdata} = 28'h0000000;
    r = $urandom(46);
    idle(3);
    reset_n <= 1'b1;
    idle(2);
    foreach (ra[i]) begin
      rd(ra[i], rv[i]); // reset values
    end
    r = 1 + $urandom % 6000;
    wr(8'h04, r[15:0]);
    rd(8'h04, r[15:0]); // any legal interval
    wr(8'h08, 16'hffff);
    rd(8'h08, 16'h1770); // upper clamp
    wr(8'h04, 16'h0000);
    rd(8'h04, 16'h0001); // lower clamp
    wr(8'h04, 16'h0004);
    wr(8'h08, 16'h0005);
    rd(8'h04, 16'h0004); // separate intervals
    $display("test registers finished");
    key_acc_run <= 1'b1;
    shed_switch_on <= 1'b1;
    idle(1 + $urandom % 8);
    volt_below_low <= 1'b1;
    idle(4);
    probe(5'h02, 3'h3); // immediate step
    idle(44);
    probe(5'h01, 3'h3); // one step
    volt_below_low <= 1'b0;
    idle(3);
    volt_below_low <= 1'b1;
    idle(4);
    probe(5'h00, 3'h3); // timer restarts
    idle(60);
    probe(5'h00, 3'h3); // stops at zero
    $display("test shed finished");
    volt_below_low <= 1'b0;
    volt_above_high <= 1'b1; // dead band kept
    idle(18);
    probe(5'h00, 3'h5); // full interval first
    idle(48);
    probe(5'h01, 3'h5); // up by one
    idle(41);
    probe(5'h02, 3'h5); // up by one again
    idle(139);
    probe(5'h03, 3'h5); // holds at maximum
    volt_below_low <= 1'b1;
    idle(60);
    probe(5'h03, 3'h7); // both true
    $display("test load finished");
    {volt_below_low, volt_above_high} <= 2'h0;
    idle(2);
    volt_below_low <= 1'b1;
    idle(4);
    {key_acc_run, volt_below_low, volt_above_high} <= 3'h1;
    idle(60);
    probe(5'h02, 3'h0); // key off holds
    key_acc_run <= 1'b1;
    idle(3);
    probe(5'h03, 3'h5); // key reload
    {volt_below_low, volt_above_high} <= 2'h2;
    idle(4);
    shed_switch_on <= 1'b0;
    idle(3);
    probe(5'h03, 3'h1); // switch reload
    $display("test reload finished");
    {shed_switch_on, volt_below_low} <= 2'h2;
    load_open <= 2'h1;
    idle(4);
    watch(4, 0); // flash without code
    load_open <= 2'h0;
    load_heavy <= 2'h2;
    idle(4);
    watch(0, 40); // overload code
    rd(8'h10, 16'h0002); // overload flag, read while the overload is still applied
    load_heavy <= 2'h0;
    idle(2);
    wr(8'h10, 16'h0002);
    idle(3);
    watch(0, 0); // cleared
    $display("test faults finished");
    give_verdict();
  end

  // Cuts a hang short; the whole sequence needs well under this.
  initial begin
    idle(3000);
    errors++;
    give_verdict();
  end
endmodule
